// ### design/tbs_sequencer.sv
// tbs_sequencer: backspace-over-one-record sequencer of the tape adapter.
// assumes all inputs synchronous to clock_i; first_bit_i is a level from read register A.
// Summary of operation
// - a call while the adapter is busy elsewhere is ignored.
// - a call with the unit at load point does nothing.
// - an accepted call sets the backspace flag, which steps the delay counter per ms.
// - in write status go turns on at count zero, moving tape forward.
// - in write status go turns off at count 50.
// - at count 96 the reverse flag sets, commanding read and backward status.
// - a unit already in read status gets no forward motion.
// - go turns on at count 160 only while selected, ready and reading.
// - read condition turns on at count 192.
// - character assembly loading from the read registers is blocked throughout.
// - a first bit runs the read clock for exactly one character cycle.
// - read clock phase seven sets the gap-timeout flag, stepping the counter.
// - delayed phase seven clears the read registers and stops the read clock in the same cycle.
// - no checking and no data transfer to the system during backspace.
// - read clock phase four clears the gap-timeout flag and zeroes the counter.
// - gap count 4 clears read condition.
// - gap count 38, 26 or 30, per unit model, turns go off.
// - gap count 64 clears the reverse flag.
// - gap count 152 clears the backspace flag; busy follows that flag.
// - gap count 152 also clears the gap-timeout flag, leaving everything idle.
module tbs_sequencer
  import tbs_pkg::*;
#(
  parameter int MS_CYCLES = tbs_pkg::MS_CYC
) (
  input  wire logic                       clock_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       bs_call_i,
  input  wire logic                       other_busy_i,
  input  wire tbs_pkg::tbs_unit_stat_type unit_stat_i,
  input  wire tbs_pkg::tbs_stop_sel_type  stop_sel_i,
  input  wire logic                       first_bit_i,
  output tbs_pkg::tbs_unit_cmd_type       unit_cmd_o,
  output logic                            busy_o,
  output logic                            rw_load_block_o,
  output logic                            check_block_o,
  output logic                            read_clock_run_o,
  output logic                            read_reg_reset_o,
  output logic                            gap_timeout_flag_o,
  output logic [tbs_pkg::CNT_W-1:0]       delay_count_o
);

  import tbs_pkg::*;

  localparam int RC_LEN_A = RC_CYCLE_CYC;
  localparam int PH_LEN   = RC_PHASE_CYC;
  localparam int PH_W     = $clog2(RC_PHASE_CYC + 1);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(RC_PHASE_CYC - 1);

  tbs_state_type      state_r;
  tbs_unit_cmd_type   cmd_r;
  logic               bs_flag_r;
  logic               gap_flag_r;
  logic               fwd_first_r;
  logic [CNT_W-1:0]   cnt_r;
  logic               rc_run_r;
  logic [2:0]         rc_ph_r;
  logic [PH_W-1:0]    rc_sub_r;
  logic               rrst_r;
  logic               tick;
  logic               step_en;
  logic               accept;
  logic               stall;
  logic               phase_end;
  logic               ph_four;
  logic               ph_seven;
  logic               ph_seven_dly;
  logic               rc_start;
  logic [CNT_W-1:0]   stop_cnt;

  // request acceptance
  assign accept = (state_r == TBS_IDLE) && bs_call_i && !other_busy_i
                  && !unit_stat_i.load_point;

  // hold the lead-in just short of 160 until the unit reports ready in read
  assign stall   = (state_r == TBS_LEAD) && (cnt_r == D_GO_ON - 8'h01)
                   && !unit_stat_i.sel_rdy_rd;
  assign step_en = ((state_r == TBS_LEAD) && !stall) || gap_flag_r;

  tbs_ms_tick #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .en_i    (step_en),
    .tick_o  (tick)
  );

  // read clock phase decode
  assign phase_end    = rc_run_r && (rc_sub_r == PH_LAST);
  assign ph_four      = phase_end && (rc_ph_r == RC_PH_FOUR - 3'h1);
  assign ph_seven     = phase_end && (rc_ph_r == RC_PH_SEVEN - 3'h1);
  assign ph_seven_dly = phase_end && (rc_ph_r == RC_PH_SEVEN);
  assign rc_start     = (state_r == TBS_READ) && cmd_r.read_cond && first_bit_i
                        && !rc_run_r;

  always_comb begin
    case (stop_sel_i)
      TBS_STOP_LONG:    stop_cnt = G_STOP_L;
      TBS_STOP_SHORT:   stop_cnt = G_STOP_S;
      TBS_STOP_COMPACT: stop_cnt = G_STOP_C;
      default:          stop_cnt = G_STOP_C;
    endcase
  end

  // sequencer state and backspace flag
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r     <= TBS_IDLE;
      bs_flag_r   <= 1'b0;
      fwd_first_r <= 1'b0;
    end else begin
      case (state_r)
        TBS_IDLE: begin
          if (accept) begin
            state_r     <= TBS_LEAD;
            bs_flag_r   <= 1'b1;
            fwd_first_r <= unit_stat_i.write_status;
          end
        end
        TBS_LEAD: begin
          if (tick && cnt_r == D_READ_ON - 8'h01) begin
            state_r <= TBS_READ;
          end
        end
        TBS_READ: begin
          if (gap_flag_r && tick && cnt_r == G_END - 8'h01) begin
            state_r   <= TBS_IDLE;
            bs_flag_r <= 1'b0;
          end
        end
        default: begin
          state_r   <= TBS_IDLE;
          bs_flag_r <= 1'b0;
        end
      endcase
    end
  end

  // delay counter: zeroed whenever neither the lead-in nor the gap flag runs it
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else if (state_r != TBS_LEAD && !gap_flag_r) begin
      cnt_r <= '0;
    end else if (state_r == TBS_LEAD && tick && cnt_r == D_READ_ON - 8'h01) begin
      cnt_r <= '0;
    end else if (tick && !stall) begin
      // a tick already in flight when ready drops must not pass the hold point
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // gap-timeout flag; phase four cannot coincide with the end count since
  // the read clock cannot start once read condition has dropped at count 4
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_flag_r <= 1'b0;
    end else if (ph_seven) begin
      gap_flag_r <= 1'b1;
    end else if (ph_four) begin
      gap_flag_r <= 1'b0;
    end else if (gap_flag_r && tick && cnt_r == G_END - 8'h01) begin
      gap_flag_r <= 1'b0;
    end
  end

  // tape unit commands
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_r <= CMD_RST;
    end else if (accept) begin
      cmd_r.go <= unit_stat_i.write_status;
    end else if (state_r == TBS_LEAD && tick && !stall) begin
      if (cnt_r == D_GO_OFF - 8'h01 && fwd_first_r) begin
        cmd_r.go <= 1'b0;
      end
      if (cnt_r == D_BACKWARD - 8'h01) begin
        cmd_r.backward <= 1'b1;
      end
      if (cnt_r == D_GO_ON - 8'h01) begin
        cmd_r.go <= 1'b1;
      end
      if (cnt_r == D_READ_ON - 8'h01) begin
        cmd_r.read_cond <= 1'b1;
      end
    end else if (state_r == TBS_READ && gap_flag_r && tick) begin
      if (cnt_r == G_READ_OFF - 8'h01) begin
        cmd_r.read_cond <= 1'b0;
      end
      if (cnt_r == stop_cnt - 8'h01) begin
        cmd_r.go <= 1'b0;
      end
      if (cnt_r == G_FORWARD - 8'h01) begin
        cmd_r.backward <= 1'b0;
      end
    end
  end

  // read clock: one character cycle per first bit
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rc_run_r <= 1'b0;
      rc_ph_r  <= 3'h0;
      rc_sub_r <= '0;
    end else if (rc_start) begin
      rc_run_r <= 1'b1;
      rc_ph_r  <= 3'h0;
      rc_sub_r <= '0;
    end else if (ph_seven_dly) begin
      rc_run_r <= 1'b0;
      rc_ph_r  <= 3'h0;
      rc_sub_r <= '0;
    end else if (phase_end) begin
      rc_ph_r  <= rc_ph_r + 3'h1;
      rc_sub_r <= '0;
    end else if (rc_run_r) begin
      rc_sub_r <= rc_sub_r + PH_W'(1);
    end
  end

  // read register clear strobe, one cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rrst_r <= 1'b0;
    end else begin
      rrst_r <= ph_seven_dly;
    end
  end

  // data path blocks follow the backspace flag: the record is only skipped
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rw_load_block_o <= 1'b0;
      check_block_o   <= 1'b0;
    end else begin
      rw_load_block_o <= bs_flag_r || accept;
      check_block_o   <= bs_flag_r || accept;
    end
  end

  assign unit_cmd_o         = cmd_r;
  assign busy_o             = bs_flag_r;
  assign read_clock_run_o   = rc_run_r;
  assign read_reg_reset_o   = rrst_r;
  assign gap_timeout_flag_o = gap_flag_r;
  assign delay_count_o      = cnt_r;

  // ---------------- assertions ----------------
  sequence s_idle_call;
    (state_r == TBS_IDLE) && bs_call_i;
  endsequence

  sequence s_lead_hit(logic [CNT_W-1:0] n);
    (state_r == TBS_LEAD) && tick && (cnt_r == n - 8'h01);
  endsequence

  sequence s_gap_hit(logic [CNT_W-1:0] n);
    (state_r == TBS_READ) && gap_flag_r && tick && (cnt_r == n - 8'h01);
  endsequence

  busy_ignore_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_idle_call ##0 other_busy_i |=> !busy_o && state_r == TBS_IDLE)
    else $error("call taken while adapter busy");

  load_point_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_idle_call ##0 unit_stat_i.load_point |=> $stable(unit_cmd_o) && !busy_o)
    else $error("call acted on at load point");

  start_go_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    accept |=> busy_o && (unit_cmd_o.go == $past(unit_stat_i.write_status)))
    else $error("go at count zero wrong for unit status");

  fwd_stop_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_lead_hit(D_GO_OFF) |=> !unit_cmd_o.go)
    else $error("go not dropped at count 50");

  reverse_on_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_lead_hit(D_BACKWARD) |=> unit_cmd_o.backward && !unit_cmd_o.read_cond)
    else $error("reverse flag not set at count 96");

  back_go_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(unit_cmd_o.go) && unit_cmd_o.backward |-> $past(unit_stat_i.sel_rdy_rd))
    else $error("backward go without ready read status");

  read_on_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_lead_hit(D_READ_ON) |=> unit_cmd_o.read_cond && state_r == TBS_READ)
    else $error("read condition not set at count 192");

  rc_length_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(read_clock_run_o) |-> ##(RC_LEN_A) !read_clock_run_o)
    else $error("read clock cycle length wrong");

  gap_set_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ph_seven |=> gap_timeout_flag_o ##(PH_LEN) gap_timeout_flag_o && !read_clock_run_o)
    else $error("gap flag not set at phase seven");

  gap_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ph_four |=> !gap_timeout_flag_o ##1 delay_count_o == '0)
    else $error("gap flag or counter not cleared at phase four");

  gap_four_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_gap_hit(G_READ_OFF) |=> !unit_cmd_o.read_cond)
    else $error("read condition not cleared at gap count 4");

  stop_go_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_gap_hit(stop_cnt) |=> !unit_cmd_o.go)
    else $error("go not dropped at gap stop count");

  fwd_status_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_gap_hit(G_FORWARD) |=> !unit_cmd_o.backward && busy_o)
    else $error("reverse flag not cleared at gap count 64");

  end_idle_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_gap_hit(G_END) |=> !busy_o && !gap_timeout_flag_o ##1 delay_count_o == '0)
    else $error("operation not ended at gap count 152");

endmodule : tbs_sequencer

// ### design/tbs_pkg.sv
// tbs_pkg: constants and carrier types for the tape backspace sequencer.
// assumes a single 50 MHz system clock; all times are converted to cycles here.
package tbs_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 20;

  // millisecond tick of the delay counter
  localparam int MS_NS  = 1000000;
  localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;

  // read clock: eight phases per character cycle
  localparam int RC_PHASE_NS  = 400;
  localparam int RC_PHASE_CYC = (RC_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_PHASES    = 8;
  localparam int RC_CYCLE_CYC = RC_PHASE_CYC * RC_PHASES;
  localparam logic [2:0] RC_PH_FOUR  = 3'h4;
  localparam logic [2:0] RC_PH_SEVEN = 3'h7;

  // delay counter width and the lead-in counts (ms)
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] D_GO_OFF   = 8'h32;  // 50
  localparam logic [CNT_W-1:0] D_BACKWARD = 8'h60;  // 96
  localparam logic [CNT_W-1:0] D_GO_ON    = 8'ha0;  // 160
  localparam logic [CNT_W-1:0] D_READ_ON  = 8'hc0;  // 192

  // gap-timeout counts (ms)
  localparam logic [CNT_W-1:0] G_READ_OFF = 8'h04;  // 4
  localparam logic [CNT_W-1:0] G_STOP_L   = 8'h26;  // 38, long-stop unit model
  localparam logic [CNT_W-1:0] G_STOP_S   = 8'h1a;  // 26, short-stop unit model
  localparam logic [CNT_W-1:0] G_STOP_C   = 8'h1e;  // 30, compact variant
  localparam logic [CNT_W-1:0] G_FORWARD  = 8'h40;  // 64
  localparam logic [CNT_W-1:0] G_END      = 8'h98;  // 152

  // go stop-point selection
  typedef enum logic [1:0] {
    TBS_STOP_LONG    = 2'h0,
    TBS_STOP_SHORT   = 2'h1,
    TBS_STOP_COMPACT = 2'h2
  } tbs_stop_sel_type;

  // sequencer states, gray along idle -> lead -> read
  typedef enum logic [1:0] {
    TBS_IDLE = 2'h0,
    TBS_LEAD = 2'h1,
    TBS_READ = 2'h3
  } tbs_state_type;

  // status lines from the selected tape unit
  typedef struct packed {
    logic load_point;
    logic write_status;
    logic sel_rdy_rd;
  } tbs_unit_stat_type;

  // command lines to the tape unit and read amplifiers
  typedef struct packed {
    logic go;
    logic backward;
    logic read_cond;
  } tbs_unit_cmd_type;

  localparam tbs_unit_cmd_type CMD_RST = '{go: 1'b0, backward: 1'b0, read_cond: 1'b0};

endpackage : tbs_pkg

// ### design/tbs_ms_tick.sv
// tbs_ms_tick: one-cycle tick every CYCLES clocks while enabled.
// assumes en_i is a level; dropping it restarts the interval from zero.
module tbs_ms_tick #(
  parameter int CYCLES = 50000
) (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic en_i,
  output logic      tick_o
);

  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_r;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else if (!en_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + W'(1);
      tick_o <= 1'b0;
    end
  end

endmodule : tbs_ms_tick

// ### sim/tbs_unit_model.sv
// tbs_unit_model: behavioural tape unit plus the first-bit source of read register A.
// assumes the sequencer's command struct; characters of one record come at a fixed pitch.
module tbs_unit_model
  import tbs_pkg::*;
#(
  parameter int PITCH = 200
) (
  input  wire logic                      clock_i,
  input  wire logic                      rst_n_i,
  input  wire tbs_pkg::tbs_unit_cmd_type unit_cmd_i,
  input  wire logic                      load_point_i,
  input  wire logic                      write_i,
  input  wire logic                      ready_i,
  input  wire logic [3:0]                n_chars_i,
  output tbs_pkg::tbs_unit_stat_type     unit_stat_o,
  output logic                           first_bit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       rd_lat_r;
  logic       rc_d_r;
  logic [3:0] left_r;
  logic [7:0] pitch_r;

  // backward leaves the unit in read status until the bench asks for write again
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) rd_lat_r <= 1'b0;
    else if (unit_cmd_i.backward) rd_lat_r <= 1'b1;
    else if (!write_i) rd_lat_r <= 1'b0;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rc_d_r  <= 1'b0;
      left_r  <= 4'h0;
      pitch_r <= 8'h00;
    end else begin
      rc_d_r <= unit_cmd_i.read_cond;
      if (unit_cmd_i.read_cond && !rc_d_r) begin
        left_r  <= n_chars_i;
        pitch_r <= 8'h00;
      end else if (left_r != 4'h0) begin
        pitch_r <= (pitch_r == 8'(PITCH - 1)) ? 8'h00 : pitch_r + 8'h01;
        if (pitch_r == 8'(PITCH - 1)) left_r <= left_r - 4'h1;
      end
    end
  end

  assign unit_stat_o.load_point   = load_point_i;
  assign unit_stat_o.write_status = write_i & ~rd_lat_r;
  assign unit_stat_o.sel_rdy_rd   = ready_i & ~unit_stat_o.write_status;
  // amplifiers pass nothing once read condition is off
  assign first_bit_o = (left_r != 4'h0) && (pitch_r < 8'h0a) && unit_cmd_i.read_cond;
endmodule : tbs_unit_model

// ### sim/tb_tbs_sequencer.sv
// tb_tbs_sequencer: self-checking bench for the backspace sequencer.
// assumes tbs_unit_model as the tape unit; the ms tick is shortened to MS cycles.
module tb_tbs_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import tbs_pkg::*;
  localparam int MS = 40;
  logic              clock_i    = 1'b0;
  logic              rst_n_i    = 1'b0;
  logic              bs_call    = 1'b0;
  logic              other_busy = 1'b0;
  logic              load_point = 1'b0;
  logic              write_st   = 1'b0;
  logic              ready      = 1'b1;
  logic [3:0]        n_chars    = 4'h1;
  tbs_stop_sel_type  stop_sel   = TBS_STOP_LONG;
  tbs_unit_stat_type unit_stat;
  tbs_unit_cmd_type  cmd;
  logic              busy, rwb, chb, run, rrr, gap, first_bit;
  logic [CNT_W-1:0]  dcount;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int t_bu, t_bd, t_gr, t_gf, t_br, t_bf, t_rr, t_rf, t_gpr, t_ru, t_rud, t_rrr, t_rdy;
  int run_len, n_run, n_gf, bad_blk, fw_go;
  logic p_busy = 0, p_go = 0, p_bk = 0, p_rc = 0, p_gap = 0, p_run = 0, p_rrr = 0, p_rdy = 0;

  initial forever #10 clock_i = ~clock_i;

  tbs_sequencer #(.MS_CYCLES(MS)) u_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .bs_call_i(bs_call), .other_busy_i(other_busy),
    .unit_stat_i(unit_stat), .stop_sel_i(stop_sel), .first_bit_i(first_bit),
    .unit_cmd_o(cmd), .busy_o(busy), .rw_load_block_o(rwb), .check_block_o(chb),
    .read_clock_run_o(run), .read_reg_reset_o(rrr), .gap_timeout_flag_o(gap),
    .delay_count_o(dcount));

  tbs_unit_model #(.PITCH(200)) u_unit (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .unit_cmd_i(cmd), .load_point_i(load_point),
    .write_i(write_st), .ready_i(ready), .n_chars_i(n_chars), .unit_stat_o(unit_stat),
    .first_bit_o(first_bit));

  // event stamps in cycles, taken from pre-edge values so they match what the design saw
  always @(posedge clock_i) begin
    cyc = cyc + 1;
    if (busy && !p_busy) begin
      t_bu = cyc;
      n_run = 0;
      n_gf = 0;
      bad_blk = 0;
      fw_go = 0;
    end
    if (!busy && p_busy) t_bd = cyc;
    if (cmd.go && !p_go) t_gr = cyc;
    if (!cmd.go && p_go) t_gf = cyc;
    if (cmd.backward && !p_bk) t_br = cyc;
    if (!cmd.backward && p_bk) t_bf = cyc;
    if (cmd.read_cond && !p_rc) t_rr = cyc;
    if (!cmd.read_cond && p_rc) t_rf = cyc;
    if (gap && !p_gap) t_gpr = cyc;
    if (!gap && p_gap) n_gf++;
    if (run && !p_run) t_ru = cyc;
    if (!run && p_run) begin
      run_len = cyc - t_ru;
      t_rud = cyc;
      n_run++;
    end
    if (rrr && !p_rrr) t_rrr = cyc;
    if (ready && !p_rdy) t_rdy = cyc;
    if (busy && !(rwb && chb)) bad_blk++;
    if (cmd.go && !cmd.backward) fw_go++;
    {p_busy, p_go, p_bk, p_rc, p_gap, p_run, p_rrr, p_rdy} =
      {busy, cmd.go, cmd.backward, cmd.read_cond, gap, run, rrr, ready};
  end

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_eq

  // cycle stamps may differ by the one-edge register delay of each output
  task automatic check_near(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (^got === 1'bx || got > exp + 2 || got + 2 < exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_near

  task automatic test_refuse();
    other_busy <= 1'b1;
    bs_call    <= 1'b1;
    repeat (4) @(posedge clock_i);
    other_busy <= 1'b0;
    load_point <= 1'b1;
    repeat (4) @(posedge clock_i);
    bs_call    <= 1'b0;
    load_point <= 1'b0;
    @(negedge clock_i);
    check_eq(busy, 0);
    check_eq(cmd, 0);
    check_eq(dcount, 0);
    check_eq({rwb, chb}, 0);
    $display("test refuse done");
  endtask : test_refuse

  task automatic run_op(input logic wr, input tbs_stop_sel_type ss, input logic [3:0] n,
                        input int stop_ms, input logic hold);
    int k;
    @(posedge clock_i);
    write_st <= wr;
    stop_sel <= ss;
    n_chars  <= n;
    ready    <= !hold;
    @(posedge clock_i);
    bs_call <= 1'b1;
    for (k = 0; k < 8 && busy !== 1'b1; k++) @(negedge clock_i);
    @(posedge clock_i);
    bs_call <= 1'b0;
    if (hold) begin
      repeat (200 * MS) @(posedge clock_i);
      ready <= 1'b1;
    end
    for (k = 0; k < 20000 && busy !== 1'b0; k++) @(negedge clock_i);
    repeat (2) @(negedge clock_i);
    check_eq(dcount, 0);
    check_eq(gap, 0);
    check_eq(cmd, 0);
    check_near(t_br - t_bu, 96 * MS);
    if (hold) check_near(t_gr - t_rdy, MS);
    else check_near(t_gr - t_bu, 160 * MS);
    check_near(t_rr - t_gr, 32 * MS);
    if (wr) check_near(fw_go, 50 * MS);
    else check_eq(fw_go, 0);
    check_eq(n_run, n);
    check_eq(run_len, RC_CYCLE_CYC);
    check_eq(t_rrr - t_rud, 0);
    check_eq(n_gf, n);
    check_near(t_rf - t_gpr, 4 * MS);
    check_near(t_gf - t_gpr, stop_ms * MS);
    check_near(t_bf - t_gpr, 64 * MS);
    check_near(t_bd - t_gpr, 152 * MS);
    check_eq(bad_blk, 0);
    check_eq({rwb, chb}, 0);
  endtask : run_op

  task automatic test_read_long();
    run_op(1'b0, TBS_STOP_LONG, 4'h3, 38, 1'b0);
    $display("test read status long stop done");
  endtask : test_read_long

  task automatic test_write_short();
    run_op(1'b1, TBS_STOP_SHORT, 4'h1, 26, 1'b0);
    $display("test write status short stop done");
  endtask : test_write_short

  task automatic test_hold_compact();
    run_op(1'b0, TBS_STOP_COMPACT, 4'h2, 30, 1'b1);
    $display("test unit not ready compact stop done");
  endtask : test_hold_compact

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    test_refuse();
    test_read_long();
    test_write_short();
    test_hold_compact();
    report_and_stop();
  end

  // the four tests need roughly 44k cycles
  initial begin
    repeat (90000) @(posedge clock_i);
    n_errors++;
    report_and_stop();
  end
endmodule : tb_tbs_sequencer
